//--- hw/smbus_port_config.sv
// configuration, busy tracking and timeout supervision for the second smbus port
// Operation
// - enable bit turns the port on and lines are watched continuously
// - inhibit bit blocks slave event interrupts; master interrupts still pass
// - hardware sets read-only busy flag while a transfer runs
// - busy flag clears on stop or on bus-free timeout
// - hold extension bit chooses normal or extended data setup and hold
// - clock-low timeout: timer reloads while clock high, counts while low
// - split-mode timer: only its high byte is held in reload
// - free timeout: both lines high over ten source periods frees bus
// - two-bit field picks timer overflow that clocks the bit rate
`timescale 1ns/1ns
module smbus_port_config
   import smbus_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic link_clk_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe_o,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic scl_pull_low_i,
   input wire logic sda_pull_low_i,
   input wire logic slave_event_i,
   input wire logic master_event_i,
   output logic irq_o,
   input wire logic timer_split_i,
   output logic timer_reload_o,
   output logic timer_high_reload_o,
   input wire overflow_type overflow_i,
   output logic bit_rate_tick_o,
   output logic port_enable_o,
   output logic [3:0] sda_hold_cycles_o,
   output logic bus_busy_o
);
   cfg_type cfg;
   logic busy;
   logic [7:0] cfg_view;
   logic link_rst;
   logic link_enable;
   lines_type link_lines;
   lines_type link_prev;
   logic start_tgl;
   logic stop_tgl;
   lines_type sys_lines;
   logic [1:0] sys_tgl;
   logic [1:0] sys_tgl_prev;
   logic start_evt;
   logic stop_evt;
   logic next_tick;
   logic [4:0] free_cnt;
   logic free_pulse;

   function automatic logic pick_source(input rate_source_type sel, input overflow_type ovf);
      case (sel)
         SRC_TIMER0: pick_source = ovf.t0;
         SRC_TIMER5: pick_source = ovf.t5;
         SRC_TIMER2_HIGH: pick_source = ovf.t2_high;
         SRC_TIMER2_LOW: pick_source = ovf.t2_low;
         default: pick_source = 1'b0;
      endcase
   endfunction

   // register write port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= cfg_type'(7'h00);
      end else if (sfr_wr_i && sfr_addr_i == CFG_ADDR) begin
         cfg.port_enable_bit <= sfr_wdata_i[BIT_ENABLE];
         cfg.slave_inhibit_bit <= sfr_wdata_i[BIT_INHIBIT];
         cfg.hold_extension_bit <= sfr_wdata_i[BIT_HOLD_EXT];
         cfg.clock_low_timeout_enable <= sfr_wdata_i[BIT_TOE];
         cfg.bus_free_timeout_enable <= sfr_wdata_i[BIT_FTE];
         cfg.bit_rate_source_select <= rate_source_type'(sfr_wdata_i[SRC_LSB +: 2]);
      end
   end

   assign cfg_view = {cfg.port_enable_bit, cfg.slave_inhibit_bit, busy,
                      cfg.hold_extension_bit, cfg.clock_low_timeout_enable,
                      cfg.bus_free_timeout_enable, cfg.bit_rate_source_select};

   // read data answers one cycle after the strobe; other addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= CFG_RESET;
      end else if (sfr_rd_i && sfr_addr_i == CFG_ADDR) begin
         sfr_rdata_o <= cfg_view;
      end else begin
         sfr_rdata_o <= CFG_RESET;
      end
   end

   // link domain: reset and enable enter through synchronisers
   sync_2ff #(.WIDTH(2)) u_link_ctl (
      .clk_i(link_clk_i),
      .async_i({rst_i, cfg.port_enable_bit}),
      .sync_o({link_rst, link_enable})
   );

   sync_2ff #(.WIDTH(2)) u_link_pins (
      .clk_i(link_clk_i),
      .async_i({scl_i, sda_i}),
      .sync_o(link_lines)
   );

   // start and stop seen on the link clock, passed over as toggles
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         link_prev <= 2'b11;
         start_tgl <= 1'b0;
         stop_tgl <= 1'b0;
      end else begin
         link_prev <= link_lines;
         if (link_enable && link_prev.port_data_line && !link_lines.port_data_line
             && link_prev.port_clock_line && link_lines.port_clock_line) begin
            start_tgl <= ~start_tgl;
         end
         if (link_enable && !link_prev.port_data_line && link_lines.port_data_line
             && link_prev.port_clock_line && link_lines.port_clock_line) begin
            stop_tgl <= ~stop_tgl;
         end
      end
   end

   sync_2ff #(.WIDTH(2)) u_sys_tgl (
      .clk_i(clk_i),
      .async_i({start_tgl, stop_tgl}),
      .sync_o(sys_tgl)
   );

   // line levels also cross for the timeout logic
   sync_2ff #(.WIDTH(2)) u_sys_pins (
      .clk_i(clk_i),
      .async_i({scl_i, sda_i}),
      .sync_o(sys_lines)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_tgl_prev <= 2'b00;
      end else begin
         sys_tgl_prev <= sys_tgl;
      end
   end

   // a disabled port drops any event still in flight
   assign start_evt = cfg.port_enable_bit && (sys_tgl[1] ^ sys_tgl_prev[1]);
   assign stop_evt = cfg.port_enable_bit && (sys_tgl[0] ^ sys_tgl_prev[0]);

   // bit-rate source
   assign next_tick = pick_source(cfg.bit_rate_source_select, overflow_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_rate_tick_o <= 1'b0;
      end else begin
         bit_rate_tick_o <= next_tick && cfg.port_enable_bit;
      end
   end

   // free timeout: count source periods with both lines high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         free_cnt <= 5'h00;
      end else if (!cfg.port_enable_bit || !cfg.bus_free_timeout_enable
                   || !sys_lines.port_clock_line || !sys_lines.port_data_line) begin
         free_cnt <= 5'h00;
      end else if (next_tick && free_cnt <= 5'(FREE_PERIODS)) begin
         free_cnt <= free_cnt + 5'h01;
      end
   end

   // more than ten periods means the eleventh tick
   assign free_pulse = next_tick && free_cnt == 5'(FREE_PERIODS) && cfg.bus_free_timeout_enable
                       && cfg.port_enable_bit && sys_lines.port_clock_line
                       && sys_lines.port_data_line;

   // busy: a start in the same cycle as a clear wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy <= 1'b0;
      end else if (start_evt) begin
         busy <= 1'b1;
      end else if (stop_evt || free_pulse || !cfg.port_enable_bit) begin
         busy <= 1'b0;
      end
   end

   assign bus_busy_o = busy;

   // interrupt gating
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= cfg.port_enable_bit && (master_event_i
                  || (slave_event_i && !cfg.slave_inhibit_bit));
      end
   end

   // companion timer control; split mode spares the low byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_reload_o <= 1'b0;
         timer_high_reload_o <= 1'b0;
      end else begin
         timer_reload_o <= cfg.clock_low_timeout_enable && cfg.port_enable_bit
                           && sys_lines.port_clock_line && !timer_split_i;
         timer_high_reload_o <= cfg.clock_low_timeout_enable && cfg.port_enable_bit
                                && sys_lines.port_clock_line;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sda_hold_cycles_o <= HOLD_CYCLES_NORMAL;
         port_enable_o <= 1'b0;
      end else begin
         sda_hold_cycles_o <= cfg.hold_extension_bit ? HOLD_CYCLES_EXTENDED
                                                     : HOLD_CYCLES_NORMAL;
         port_enable_o <= cfg.port_enable_bit;
      end
   end

   // open-drain pins only ever pull low, and only when enabled
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = cfg.port_enable_bit && scl_pull_low_i;
   assign sda_oe_o = cfg.port_enable_bit && sda_pull_low_i;

   sequence s_free_seen;
      free_pulse && !start_evt;
   endsequence

   sequence s_start_seen;
      start_evt;
   endsequence

   chk_start_sets_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      s_start_seen |=> busy && bus_busy_o) else $error("busy not set after start");
   chk_stop_clears_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      stop_evt && !start_evt |=> !busy) else $error("busy not cleared by stop");
   chk_free_clears_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      s_free_seen |=> !busy && free_cnt == 5'(FREE_PERIODS + 1)) else $error("free timeout");
   chk_slave_inhibit_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      slave_event_i && !master_event_i && cfg.slave_inhibit_bit |=> !irq_o)
      else $error("slave irq not inhibited");
   chk_master_irq_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      master_event_i && cfg.port_enable_bit |=> irq_o) else $error("master irq lost");
   chk_reload_full: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg.clock_low_timeout_enable && cfg.port_enable_bit && !timer_split_i
      && !sys_lines.port_clock_line |=> !timer_reload_o && !timer_high_reload_o)
      else $error("timer held while clock low");
   chk_reload_split: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg.clock_low_timeout_enable && cfg.port_enable_bit && timer_split_i
      && sys_lines.port_clock_line |=> timer_high_reload_o && !timer_reload_o)
      else $error("split reload wrong");
   chk_source_tick: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg.port_enable_bit && cfg.bit_rate_source_select == SRC_TIMER2_LOW
      && overflow_i.t2_low |=> bit_rate_tick_o) else $error("source tick missing");
   chk_disabled_release: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg.port_enable_bit |-> !scl_oe_o && !sda_oe_o && !start_evt)
      else $error("disabled port active");
   chk_hold_select: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg.hold_extension_bit ##1 cfg.hold_extension_bit |->
      sda_hold_cycles_o == HOLD_CYCLES_EXTENDED) else $error("hold timing wrong");
endmodule

//--- hw/smbus_cfg_pkg.sv
// shared constants and types for the smbus port configuration block
package smbus_cfg_pkg;
   localparam logic [7:0] CFG_ADDR = 8'hc1;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam int BIT_ENABLE = 7;
   localparam int BIT_INHIBIT = 6;
   localparam int BIT_BUSY = 5;
   localparam int BIT_HOLD_EXT = 4;
   localparam int BIT_TOE = 3;
   localparam int BIT_FTE = 2;
   localparam int SRC_LSB = 0;
   localparam int FREE_PERIODS = 10;
   localparam logic [3:0] HOLD_CYCLES_NORMAL = 4'h1;
   localparam logic [3:0] HOLD_CYCLES_EXTENDED = 4'h4;

   typedef enum logic [1:0] {
      SRC_TIMER0,
      SRC_TIMER5,
      SRC_TIMER2_HIGH,
      SRC_TIMER2_LOW
   } rate_source_type;

   typedef struct packed {
      logic port_enable_bit;
      logic slave_inhibit_bit;
      logic hold_extension_bit;
      logic clock_low_timeout_enable;
      logic bus_free_timeout_enable;
      rate_source_type bit_rate_source_select;
   } cfg_type;

   typedef struct packed {
      logic port_clock_line;
      logic port_data_line;
   } lines_type;

   typedef struct packed {
      logic t0;
      logic t5;
      logic t2_high;
      logic t2_low;
   } overflow_type;
endpackage

//--- hw/sync_2ff.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ns
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;

   // stage1 is read only by the second stage
   always_ff @(posedge clk_i) begin
      stage1 <= async_i;
      sync_o <= stage1;
   end
endmodule

//--- tb/smbus_bus_model.sv
// two-wire bus model: far-side master with pull-ups on both lines
`timescale 1ns/1ns
module smbus_bus_model (
   input wire logic scl_oe_i,
   input wire logic sda_oe_i,
   output wire logic scl_o,
   output wire logic sda_o
);
   logic scl_drv = 1'b1;
   logic sda_drv = 1'b1;
   // pull-up plus wired-and, so a released line reads high
   assign scl_o = scl_drv & ~scl_oe_i;
   assign sda_o = sda_drv & ~sda_oe_i;
   // slow steps so both clock domains see every level
   task step(input logic c, input logic d);
      scl_drv = c;
      sda_drv = d;
      #256;
   endtask
   // ends with both lines high but the bus still taken
   task start_frame;
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
   endtask
   task stop_frame;
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
endmodule

//--- tb/smbus_port_config_test.sv
// self-checking bench for the smbus port configuration block
`timescale 1ns/1ns
module smbus_port_config_test;
   import smbus_cfg_pkg::*;
   logic clk_i = 0, rst_i = 1, link_clk_i = 0;
   logic [7:0] addr = 0, wdata = 0, rdata;
   logic wr = 0, rd = 0, rd_d = 0, scl_pl = 0, sda_pl = 0, sev = 0, mev = 0, split = 0;
   logic scl, sda, scl_o, sda_o, scl_oe, sda_oe, irq, trl, thr, tick, pen, busy;
   logic [3:0] hold;
   overflow_type ovf = '0;
   overflow_type o;
   logic [7:0] exp_q[$];
   int num_errors = 0, num_checks = 0;
   always #2 clk_i = ~clk_i;
   initial #7 forever #32 link_clk_i = ~link_clk_i;
   smbus_bus_model smbus_bus_model_inst (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl),
      .sda_o(sda));
   smbus_port_config smbus_port_config_inst (.clk_i(clk_i), .rst_i(rst_i),
      .link_clk_i(link_clk_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
      .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .scl_i(scl), .sda_i(sda), .scl_o(scl_o),
      .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe), .scl_pull_low_i(scl_pl),
      .sda_pull_low_i(sda_pl), .slave_event_i(sev), .master_event_i(mev), .irq_o(irq),
      .timer_split_i(split), .timer_reload_o(trl), .timer_high_reload_o(thr),
      .overflow_i(ovf), .bit_rate_tick_o(tick), .port_enable_o(pen),
      .sda_hold_cycles_o(hold), .bus_busy_o(busy));
   task cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD reg t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmp_out(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD out t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // read data stands one cycle, so the monitor looks exactly then
   always @(posedge clk_i) begin
      rd_d <= rd;
      if (rd_d) cmp_reg(rdata, exp_q.pop_front());
   end
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk_i);
      wr <= 0;
   endtask
   task rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr <= a;
      rd <= 1;
      exp_q.push_back(e);
      @(posedge clk_i);
      rd <= 0;
   endtask
   task pulse(input logic s, input logic m, input overflow_type v);
      @(posedge clk_i);
      sev <= s;
      mev <= m;
      ovf <= v;
      @(posedge clk_i);
      sev <= 0;
      mev <= 0;
      ovf <= '0;
      #1;
   endtask
   task wrap_up;
      repeat (2) @(posedge clk_i);
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      wrap_up;
   end
   initial begin
      void'($urandom(32'hdfaf_822c));
      // link side resets through a synchronised copy, so hold in link clocks
      repeat (4) @(posedge link_clk_i);
      @(posedge clk_i);
      rst_i <= 0;
      #1 cmp_out(hold, 8'h01);
      rd_reg(8'hc1, 8'h00);
      wr_reg(8'hc0, 8'hff);
      rd_reg(8'hc0, 8'h00);
      rd_reg(8'hc1, 8'h00);
      scl_pl <= 1;
      sda_pl <= 1;
      #1 cmp_out({scl_oe, sda_oe}, 8'h00);
      cmp_out({scl_o, sda_o}, 8'h00);
      @(posedge clk_i);
      sda_pl <= 0;
      wr_reg(8'hc1, 8'hff);
      // enable copy is registered, so it shows one edge after the write
      @(posedge clk_i);
      #1 cmp_out({pen, scl_oe}, 8'h03);
      repeat (5) @(posedge clk_i);
      sda_pl <= 1;
      #1 cmp_out({trl, thr, sda_oe}, 8'h01);
      @(posedge clk_i);
      sda_pl <= 0;
      repeat (4) @(posedge clk_i);
      scl_pl <= 0;
      repeat (8) @(posedge clk_i);
      #1 cmp_out({trl, thr}, 8'h03);
      split <= 1;
      repeat (4) @(posedge clk_i);
      #1 cmp_out({trl, thr}, 8'h01);
      rd_reg(8'hc1, 8'hdf);
      cmp_out(hold, 8'h04);
      pulse(1, 0, '0);
      cmp_out(irq, 8'h00);
      pulse(0, 1, '0);
      cmp_out(irq, 8'h01);
      wr_reg(8'hc1, 8'h80);
      pulse(1, 0, '0);
      cmp_out({irq, hold}, 8'h11);
      for (int s = 0; s < 4; s++) begin
         wr_reg(8'hc1, 8'h80 | 8'(s));
         repeat (4) begin
            o = overflow_type'(4'($urandom));
            pulse(0, 0, o);
            cmp_out(tick, {7'h00, o[3 - s]});
         end
      end
      wr_reg(8'hc1, 8'h80);
      smbus_bus_model_inst.start_frame();
      cmp_out(busy, 8'h01);
      rd_reg(8'hc1, 8'ha0);
      smbus_bus_model_inst.stop_frame();
      repeat (8) @(posedge link_clk_i);
      cmp_out(busy, 8'h00);
      wr_reg(8'hc1, 8'h84);
      smbus_bus_model_inst.start_frame();
      repeat (8) @(posedge link_clk_i);
      // more than ten periods: the tenth tick must not yet free the bus
      repeat (10) pulse(0, 0, overflow_type'(4'h8));
      repeat (2) @(posedge clk_i);
      cmp_out(busy, 8'h01);
      pulse(0, 0, overflow_type'(4'h8));
      repeat (2) @(posedge clk_i);
      #1 cmp_out(busy, 8'h00);
      rd_reg(8'hc1, 8'h84);
      wrap_up;
   end
endmodule
